// file: hw/fsr_cmd_rx.sv
// Link-side shifter: counts link clock edges of one frame and keeps its first 32 bits.
// Assumes the link clock stands still while chip select is high, so outputs are
// quasi-static when the system side samples them after chip select rises.
`timescale 1ns/1ns
module fsr_cmd_rx
    import fsr_pkg::*;
(
    input  wire logic              sclk,     // Link clock
    input  wire logic              rst_n,    // Power-on reset, active low
    input  wire logic              cs_n,     // Chip select, active low
    input  wire logic [3:0]        sio_in,   // Data lines
    output logic      [EDGE_W-1:0] edges,    // Edges in last frame
    output logic      [31:0]       bits_one, // One-line bits, last in lsb
    output logic      [31:0]       bits_four // Four-line bits, last in lsb
);
    typedef struct packed {
        logic [EDGE_W-1:0] edges;
        logic [31:0]       s1;
        logic [31:0]       s4;
    } fsr_rx_s;

    fsr_rx_s r_ff;
    fsr_rx_s nxt_r;
    logic    frame_ff;

    // Frame flag is cleared by chip select itself, since no clock runs between frames
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
            frame_ff <= 1'b0;
        else
            frame_ff <= 1'b1;
    end

    // Shift: upper data lines only enter the four-line copy
    always_comb
    begin
        nxt_r = r_ff;
        if (!frame_ff)
        begin
            nxt_r.edges = {{(EDGE_W-1){1'b0}}, 1'b1};
            nxt_r.s1    = {31'h0, sio_in[0]};           // see [R7]
            nxt_r.s4    = {28'h0, sio_in};
        end
        else
        begin
            if (r_ff.edges != {EDGE_W{1'b1}})
                nxt_r.edges = r_ff.edges + 1'b1;
            if (r_ff.edges < 16'd32)
                nxt_r.s1 = {r_ff.s1[30:0], sio_in[0]};
            if (r_ff.edges < 16'd8)
                nxt_r.s4 = {r_ff.s4[27:0], sio_in};
        end
    end

    always_ff @(posedge sclk or negedge rst_n)
    begin
        if (!rst_n)
            r_ff <= '0;
        else
            r_ff <= nxt_r;
    end

    assign edges     = r_ff.edges;
    assign bits_one  = r_ff.s1;
    assign bits_four = r_ff.s4;

endmodule

// file: hw/fsr_flash_ctl.sv
// Command sequencer for program/erase suspend and resume, no-operation and soft reset.
// Assumes a host that drives chip select, link clock and data lines, and a flash core
// that follows WIP and the reset pulse.
// What this block does, and what it expects of the host
// [R1] Keep a 64-bit hidden password in one-time programmable storage.
// [R2] Once password mode bit is zero, never return the password.
// [R3] Let a suspend command interrupt sector erase, block erase or page program.
// [R4] Show program-suspended in bit 2 and erase-suspended in bit 3.
// [R5] Be suspended and ready within 20 us of taking a suspend.
// [R6] Host waits 1 ms after resume before another suspend.
// [R7] Take these commands as 8 one-line clocks or 2 four-line clocks.
// [R8] During erase suspend, reads of the suspended region are flagged invalid.
// [R9] Erase suspend clears write enable and filters commands to a fixed list.
// [R10] Erase suspend never takes effect before 20 us of erasing.
// [R11] Erase-suspended flag set on suspend, cleared on resume.
// [R12] During program suspend, reads of the suspended region are flagged invalid.
// [R13] Program suspend clears write enable and filters commands to a fixed list.
// [R14] Program-suspended flag set on suspend, cleared on resume.
// [R15] Single opcode 30h resumes the write and clears the suspend flag.
// [R16] Resume needs no prior write enable.
// [R17] Host learns completion by polling busy or waiting the full time.
// [R18] Refuse resume while performance enhance mode is on.
// [R19] No-operation only cancels a pending reset arm.
// [R20] Reset acts only right after reset arm; anything between cancels.
// [R21] Soft reset returns every volatile setting to its power-on value.
// [R22] Soft reset aborts a running program or erase.
// [R23] Chip select off a byte boundary rejects the instruction.
// [R24] Host waits a recovery time after soft reset.
`timescale 1ns/1ns
module fsr_flash_ctl
    import fsr_pkg::*;
#(
    parameter int SECTOR_ERASE_TIME_US = 40000,  // Sector erase duration
    parameter int BLOCK_ERASE_TIME_US  = 500000, // Block erase duration
    parameter int PAGE_PROGRAM_TIME_US = 1000    // Page program duration
)
(
    input  wire logic        CLK_SYS,         // System clock, 20 MHz
    input  wire logic        NRST,            // Power-on reset, active low
    input  wire logic        SCLK,            // Link clock
    input  wire logic        CS_N,            // Chip select, active low
    input  wire logic [3:0]  SIO_IN,          // Data lines in
    input  wire logic        PERF_MODE,       // Performance enhance mode active
    input  wire logic        LOCK_PWD_MODE_N, // Lock bit 2
    input  wire logic        PWD_PROG,        // Password program pulse
    input  wire logic [63:0] PWD_PROG_DATA,   // Password program data
    input  wire logic [23:0] RD_ADDR,         // Read address from read path
    output logic      [63:0] PWD_RDATA,       // Password readback
    output logic             RD_BLOCKED,      // Read hits suspended region
    output logic             WIP,             // Write in progress
    output logic             WRITE_ENABLE_LATCH,             // Write enable latch
    output logic      [7:0]  SECURITY_STATUS, // Suspend flags
    output logic             FOUR_LINE_MODE,  // Four-line command mode
    output logic             SW_RESET_PULSE,  // Soft reset to the rest of the device
    output logic             CMD_REJECTED     // Frame rejected or filtered
);
    localparam int          SE_CYC    = SECTOR_ERASE_TIME_US * SYS_CLK_MHZ;
    localparam int          BE_CYC    = BLOCK_ERASE_TIME_US * SYS_CLK_MHZ;
    localparam int          PP_CYC    = PAGE_PROGRAM_TIME_US * SYS_CLK_MHZ;
    localparam logic [CNT_W-1:0] SUSP_MIN = CNT_W'(SUSP_LAT_CYC);
    localparam int          SUSP_BOUND = SUSP_LAT_CYC;

    typedef struct packed {
        logic             cs_s1;
        logic             cs_s2;
        logic             cs_s3;
        logic             cs_stable;
        fsr_op_e          state;
        fsr_kind_e        kind;
        logic [23:0]      addr;
        logic [CNT_W-1:0] remain;
        logic [CNT_W-1:0] elapsed;
        logic             write_enable_latch;
        logic             program_suspended_flag;
        logic             erase_suspended_flag;
        logic             four;
        logic             rst_arm;
        logic             sw_rst;
        logic             rejected;
        logic             rd_blk;
    } fsr_ctl_s;

    fsr_ctl_s          r_ff;
    fsr_ctl_s          nxt_r;
    logic [EDGE_W-1:0] rx_edges;
    logic [31:0]       rx_one;
    logic [31:0]       rx_four;
    logic              cs_rise;
    logic              boundary;
    logic [EDGE_W-1:0] nbytes;
    logic [31:0]       bits;
    logic [7:0]        opcode;
    logic [23:0]       op_addr;
    logic              single;
    logic              cmd_go;
    logic              filtered;
    logic              nop_go;
    logic              resume_go;
    logic              susp_effect;

    // Commands that survive a suspend; reads, status, resume and reset, plus write enable/disable, four-line on/off and no-operation among others
    function automatic logic allowed_in_suspend(input logic [7:0] op);
        case (op)
            8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb, 8'h5a, 8'hc0,
            8'h06, 8'h04, 8'h2b, 8'h9f, 8'haf, 8'h05, 8'hab, 8'h90,
            8'hb1, 8'hc1, 8'hb0, 8'h30, 8'h66, 8'h99, 8'h00, 8'h35,
            8'hf5, 8'h15, 8'h2d, 8'h27, 8'ha7, 8'he2, 8'he0, 8'h16,
            8'h08, 8'h38, 8'h68, 8'h88, 8'he8, 8'h28, 8'ha8, 8'h81,
            8'h80:   allowed_in_suspend = 1'b1;
            default: allowed_in_suspend = 1'b0;
        endcase
    endfunction

    // Region of an operation, shared by the read check
    function automatic logic same_region(input fsr_kind_e k, input logic [23:0] a, input logic [23:0] b);
        if (k == K_BLOCK)
            same_region = (a[23:BLOCK_SHIFT] == b[23:BLOCK_SHIFT]);
        else
            same_region = (a[23:SECTOR_SHIFT] == b[23:SECTOR_SHIFT]);
    endfunction

    fsr_cmd_rx u_rx (
        .sclk      (SCLK),
        .rst_n     (NRST),
        .cs_n      (CS_N),
        .sio_in    (SIO_IN),
        .edges     (rx_edges),
        .bits_one  (rx_one),
        .bits_four (rx_four)
    );

    fsr_pwd_store u_pwd (
        .clk        (CLK_SYS),
        .rst_n      (NRST),
        .prog       (PWD_PROG),
        .prog_data  (PWD_PROG_DATA),
        .pwd_mode_n (LOCK_PWD_MODE_N),
        .rd_data    (PWD_RDATA)
    );

    // Frame decode once chip select has settled high; link data is frozen by then
    always_comb
    begin
        cs_rise = (r_ff.cs_s2 == r_ff.cs_s3) && r_ff.cs_s3 && !r_ff.cs_stable;
        bits    = r_ff.four ? rx_four : rx_one;
        if (r_ff.four)
        begin
            boundary = !rx_edges[0];                           // see [R7]
            nbytes   = rx_edges >> 1;
        end
        else
        begin
            boundary = (rx_edges[2:0] == 3'h0);                // see [R23]
            nbytes   = rx_edges >> 3;
        end
        if (nbytes >= 16'd4)
            opcode = bits[31:24];
        else if (nbytes == 16'd3)
            opcode = bits[23:16];
        else if (nbytes == 16'd2)
            opcode = bits[15:8];
        else
            opcode = bits[7:0];
        op_addr   = bits[23:0];
        single    = (nbytes == 16'd1);
        cmd_go    = cs_rise && boundary && (nbytes != 16'd0);
        filtered  = cmd_go && (r_ff.state == ST_SUSP) && !allowed_in_suspend(opcode); // see [R9] [R13]
        nop_go    = cmd_go && single && (opcode == OP_NO_OPERATION);
        resume_go = cmd_go && !filtered && single && (opcode == OP_RESUME)
                    && (r_ff.state == ST_SUSP) && !PERF_MODE;  // see [R15] [R16] [R18]
        susp_effect = (r_ff.state == ST_SUSP_WAIT) && (r_ff.remain > 1)
                      && ((r_ff.kind == K_PAGE) || (r_ff.elapsed >= SUSP_MIN)); // see [R5] [R10]
    end

    // Main sequencer
    always_comb
    begin
        nxt_r           = r_ff;
        nxt_r.cs_s1     = CS_N;
        nxt_r.cs_s2     = r_ff.cs_s1;
        nxt_r.cs_s3     = r_ff.cs_s2;
        if (r_ff.cs_s2 == r_ff.cs_s3)
            nxt_r.cs_stable = r_ff.cs_s3;
        nxt_r.sw_rst    = 1'b0;
        nxt_r.rejected  = cs_rise && (!cmd_go || filtered);

        // Running operation keeps time, also while a suspend is pending
        if ((r_ff.state == ST_BUSY) || (r_ff.state == ST_SUSP_WAIT))
        begin
            if (r_ff.elapsed < SUSP_MIN)
                nxt_r.elapsed = r_ff.elapsed + 1'b1;
            if (r_ff.remain <= 1)
            begin
                nxt_r.state  = ST_IDLE;
                nxt_r.kind   = K_NONE;
                nxt_r.remain = '0;
            end
            else
                nxt_r.remain = r_ff.remain - 1'b1;
        end

        if (susp_effect)
        begin
            nxt_r.state  = ST_SUSP;                             // see [R3]
            nxt_r.write_enable_latch    = 1'b0;                                // see [R9] [R13]
            nxt_r.remain = r_ff.remain;
            nxt_r.erase_suspended_flag    = (r_ff.kind != K_PAGE);               // see [R4] [R11]
            nxt_r.program_suspended_flag    = (r_ff.kind == K_PAGE);               // see [R4] [R14]
        end

        // Any frame, rejected or not, ends a pending reset arm
        if (cs_rise)
            nxt_r.rst_arm = 1'b0;                               // see [R20]

        if (cmd_go && !filtered)
        begin
            case (opcode)
                OP_RESET_ARM:
                    nxt_r.rst_arm = single;
                OP_WRITE_ENABLE:
                    if (single && r_ff.state != ST_BUSY && r_ff.state != ST_SUSP_WAIT)
                        nxt_r.write_enable_latch = 1'b1;
                OP_WRITE_DISABLE:
                    if (single && r_ff.state != ST_BUSY && r_ff.state != ST_SUSP_WAIT)
                        nxt_r.write_enable_latch = 1'b0;
                OP_FOUR_LINE_ON:
                    if (single && r_ff.state != ST_BUSY)
                        nxt_r.four = 1'b1;
                OP_FOUR_LINE_OFF:
                    if (single && r_ff.state != ST_BUSY)
                        nxt_r.four = 1'b0;
                OP_SUSPEND:
                    if (single && r_ff.state == ST_BUSY)
                        nxt_r.state = ST_SUSP_WAIT;             // see [R3]
                OP_RESUME:
                    if (resume_go)
                    begin
                        nxt_r.state = ST_BUSY;                  // see [R15]
                        nxt_r.erase_suspended_flag   = 1'b0;                     // see [R11]
                        nxt_r.program_suspended_flag   = 1'b0;                     // see [R14]
                    end
                OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_PAGE_PROGRAM:
                    if (r_ff.state == ST_IDLE && r_ff.write_enable_latch && (nbytes >= 16'd4)
                        && ((opcode != OP_PAGE_PROGRAM) ? (nbytes == 16'd4) : (nbytes >= 16'd5)))
                    begin
                        nxt_r.state   = ST_BUSY;
                        nxt_r.write_enable_latch     = 1'b0;
                        nxt_r.addr    = op_addr;
                        nxt_r.elapsed = '0;
                        if (opcode == OP_SECTOR_ERASE)
                        begin
                            nxt_r.kind   = K_SECTOR;
                            nxt_r.remain = CNT_W'(SE_CYC);
                        end
                        else if (opcode == OP_BLOCK_ERASE)
                        begin
                            nxt_r.kind   = K_BLOCK;
                            nxt_r.remain = CNT_W'(BE_CYC);
                        end
                        else
                        begin
                            nxt_r.kind   = K_PAGE;
                            nxt_r.remain = CNT_W'(PP_CYC);
                        end
                    end
                default:
                    nxt_r.rst_arm = 1'b0;                       // see [R19]
            endcase

            // Soft reset: back to power-on values, running operation dropped
            if (single && opcode == OP_RESET && r_ff.rst_arm)
            begin
                nxt_r.state   = ST_IDLE;                        // see [R21] [R22]
                nxt_r.kind    = K_NONE;
                nxt_r.remain  = '0;
                nxt_r.elapsed = '0;
                nxt_r.addr    = '0;
                nxt_r.write_enable_latch     = 1'b0;
                nxt_r.program_suspended_flag     = 1'b0;
                nxt_r.erase_suspended_flag     = 1'b0;
                nxt_r.four    = 1'b0;
                nxt_r.sw_rst  = 1'b1;
            end
        end

        // Reads into the suspended region are flagged; the host must drop that data
        nxt_r.rd_blk = (nxt_r.state == ST_SUSP) && same_region(nxt_r.kind, nxt_r.addr, RD_ADDR); // see [R8] [R12]
    end

    // Sync flops start high so no frame end is seen at release of reset
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            r_ff           <= '0;
            r_ff.cs_s1     <= 1'b1;
            r_ff.cs_s2     <= 1'b1;
            r_ff.cs_s3     <= 1'b1;
            r_ff.cs_stable <= 1'b1;
            r_ff.state     <= ST_IDLE;
            r_ff.kind      <= K_NONE;
        end
        else
            r_ff <= nxt_r;
    end

    // Outputs straight from flops, except WIP, decoded from the state
    always_comb
    begin
        SECURITY_STATUS              = 8'h00;
        SECURITY_STATUS[SEC_PSB_BIT] = r_ff.program_suspended_flag;
        SECURITY_STATUS[SEC_ESB_BIT] = r_ff.erase_suspended_flag;
    end
    assign WIP            = (r_ff.state == ST_BUSY) || (r_ff.state == ST_SUSP_WAIT);
    assign WRITE_ENABLE_LATCH            = r_ff.write_enable_latch;
    assign FOUR_LINE_MODE = r_ff.four;
    assign SW_RESET_PULSE = r_ff.sw_rst;
    assign CMD_REJECTED   = r_ff.rejected;
    assign RD_BLOCKED     = r_ff.rd_blk;

    // Checks
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);

    susp_ready_a: assert property ( // see [R5]
        $rose(r_ff.state == ST_SUSP_WAIT) |-> ##[1:SUSP_BOUND] (r_ff.state != ST_SUSP_WAIT))
        else $error("suspend not ready in time");
    erase_hold_a: assert property ( // see [R10]
        $rose(r_ff.state == ST_SUSP) && r_ff.erase_suspended_flag |-> r_ff.elapsed >= SUSP_MIN)
        else $error("erase suspended too early");
    flag_kind_a: assert property ( // see [R4] [R11] [R14]
        $rose(r_ff.state == ST_SUSP) |-> SECURITY_STATUS[SEC_ESB_BIT] == (r_ff.kind != K_PAGE)
                                          && SECURITY_STATUS[SEC_PSB_BIT] == (r_ff.kind == K_PAGE))
        else $error("suspend flag does not match operation");
    wel_drop_a: assert property ( // see [R9] [R13]
        $rose(r_ff.state == ST_SUSP) |-> !WRITE_ENABLE_LATCH)
        else $error("write enable kept on suspend");
    resume_clear_a: assert property ( // see [R15] [R16]
        resume_go |=> WIP && SECURITY_STATUS == 8'h00)
        else $error("resume did not restart write");
    perf_block_a: assert property ( // see [R18]
        cmd_go && single && opcode == OP_RESUME && r_ff.state == ST_SUSP && PERF_MODE
        |=> r_ff.state == ST_SUSP && $stable(SECURITY_STATUS))
        else $error("resume taken in performance mode");
    reset_pair_a: assert property ( // see [R20] [R21] [R22]
        SW_RESET_PULSE |-> $past(r_ff.rst_arm) && !WIP && !WRITE_ENABLE_LATCH && SECURITY_STATUS == 8'h00 && !FOUR_LINE_MODE)
        else $error("soft reset without arm or incomplete");
    nop_only_a: assert property ( // see [R19]
        nop_go |=> !r_ff.rst_arm && $stable(WRITE_ENABLE_LATCH) && $stable(FOUR_LINE_MODE) && !SW_RESET_PULSE)
        else $error("no-operation changed state");
    filter_a: assert property ( // see [R9] [R13]
        filtered |=> $stable(WRITE_ENABLE_LATCH) && $stable(FOUR_LINE_MODE) && CMD_REJECTED)
        else $error("filtered command executed");
    reject_a: assert property ( // see [R23]
        cs_rise && !boundary |=> CMD_REJECTED && !r_ff.rst_arm && $stable(WRITE_ENABLE_LATCH))
        else $error("off-boundary frame executed");

    susp_erase_c:  cover property ($rose(r_ff.erase_suspended_flag));
    susp_prog_c:   cover property ($rose(r_ff.program_suspended_flag));
    resume_c:      cover property (resume_go);
    soft_reset_c:  cover property (SW_RESET_PULSE && $past(WIP));

endmodule

// file: hw/fsr_pkg.sv
// Shared constants for the suspend/resume/reset command block of the serial flash.
// Assumes a 20 MHz system clock and a serial link sampled on the rising link clock.
package fsr_pkg;

    // Timing
    localparam int SYS_CLK_MHZ    = 20;
    localparam int SUSP_LAT_US    = 20;
    localparam int SUSP_LAT_CYC   = SUSP_LAT_US * SYS_CLK_MHZ;  // 400 cycles, longest time rounds down
    localparam int RESUME_GAP_US  = 1000;                       // Host spacing resume to next suspend
    localparam int RESUME_GAP_CYC = RESUME_GAP_US * SYS_CLK_MHZ;
    localparam int CNT_W          = 32;
    localparam int EDGE_W         = 16;

    // Opcodes
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_RESUME        = 8'h30;
    localparam logic [7:0] OP_SUSPEND       = 8'hb0;
    localparam logic [7:0] OP_RESET_ARM     = 8'h66;
    localparam logic [7:0] OP_RESET         = 8'h99;
    localparam logic [7:0] OP_NO_OPERATION  = 8'h00;
    localparam logic [7:0] OP_FOUR_LINE_ON  = 8'h35;
    localparam logic [7:0] OP_FOUR_LINE_OFF = 8'hf5;
    localparam logic [7:0] OP_SECTOR_ERASE  = 8'h20;
    localparam logic [7:0] OP_BLOCK_ERASE   = 8'hd8;
    localparam logic [7:0] OP_PAGE_PROGRAM  = 8'h02;

    // Field positions and defaults
    localparam int          SEC_PSB_BIT     = 2;
    localparam int          SEC_ESB_BIT     = 3;
    localparam int          LOCK_PWD_BIT    = 2;
    localparam int          SECTOR_SHIFT    = 12;
    localparam int          BLOCK_SHIFT     = 16;
    localparam logic [63:0] PWD_DEFAULT     = 64'hffff_ffff_ffff_ffff;
    localparam logic [63:0] PWD_HIDDEN      = 64'h0000_0000_0000_0000;

    typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_SUSP_WAIT, ST_SUSP} fsr_op_e;
    typedef enum logic [1:0] {K_NONE, K_SECTOR, K_BLOCK, K_PAGE} fsr_kind_e;

endpackage

// file: hw/fsr_pwd_store.sv
// Hidden 64-bit password store, one-time programmable: programming can only clear bits.
// Assumes power-on reset stands for the factory blank state; soft reset never touches it.
`timescale 1ns/1ns
module fsr_pwd_store
    import fsr_pkg::*;
(
    input  wire logic        clk,        // System clock
    input  wire logic        rst_n,      // Power-on reset, active low
    input  wire logic        prog,       // Program pulse
    input  wire logic [63:0] prog_data,  // Bits to clear where zero
    input  wire logic        pwd_mode_n, // Lock bit 2, zero once password mode chosen
    output logic      [63:0] rd_data     // Readback, hidden in password mode
);
    typedef struct packed {
        logic [63:0] pwd;
        logic [63:0] rd;
    } fsr_pwd_s;

    fsr_pwd_s r_ff;
    fsr_pwd_s nxt_r;

    // Programming is refused once password mode is locked in
    always_comb
    begin
        nxt_r = r_ff;
        if (prog && pwd_mode_n)
            nxt_r.pwd = r_ff.pwd & prog_data;          // see [R1]
        nxt_r.rd = pwd_mode_n ? nxt_r.pwd : PWD_HIDDEN; // see [R2]
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            r_ff <= {PWD_DEFAULT, PWD_DEFAULT};
        else
            r_ff <= nxt_r;
    end

    assign rd_data = r_ff.rd;

    hidden_read_a: assert property (@(posedge clk) disable iff (!rst_n) // see [R2]
        !pwd_mode_n |=> rd_data == PWD_HIDDEN)
        else $error("password visible in password mode");

endmodule

// file: sim/fsr_flash_ctl_tb.sv
// Bench for the suspend/resume/reset block: random password and addresses, seed 25.
// Assumes the host model drives the link with a 6 ns clock only inside frames.
`timescale 1ns/1ns
module fsr_flash_ctl_tb;
    import fsr_pkg::*;
    logic        clk = 0, nrst = 0, perf = 0, lock_n = 1, prog = 0, sclk, cs_n;
    logic        blk, wip, write_enable_latch, four, srst, rej;
    logic [3:0]  sio;
    logic [7:0]  sec;
    logic [23:0] ra = 0, a;
    logic [63:0] pd = 0, prd;
    int          err_count = 0, total_checks = 0, seed = 25, rej_cnt = 0, srst_cnt = 0, i, r0;

    fsr_flash_ctl #(.SECTOR_ERASE_TIME_US(50), .BLOCK_ERASE_TIME_US(100), .PAGE_PROGRAM_TIME_US(30))
    fsr_flash_ctl_inst (.CLK_SYS(clk), .NRST(nrst), .SCLK(sclk), .CS_N(cs_n), .SIO_IN(sio), .PERF_MODE(perf),
        .LOCK_PWD_MODE_N(lock_n), .PWD_PROG(prog), .PWD_PROG_DATA(pd), .RD_ADDR(ra), .PWD_RDATA(prd),
        .RD_BLOCKED(blk), .WIP(wip), .WRITE_ENABLE_LATCH(write_enable_latch), .SECURITY_STATUS(sec), .FOUR_LINE_MODE(four),
        .SW_RESET_PULSE(srst), .CMD_REJECTED(rej));
    fsr_host_model fsr_host_model_inst (.sclk(sclk), .cs_n(cs_n), .sio(sio));

    // System clock, 50 ns
    initial
        forever #25 clk = ~clk;
    // One-cycle pulses are counted so no check can miss them
    always @(posedge clk)
    begin
        if (rej === 1'b1) rej_cnt++;
        if (srst === 1'b1) srst_cnt++;
    end
    // Hang guard
    initial
    begin
        repeat (30000) @(posedge clk);
        err_count++;
        final_report();
    end

    function automatic logic [7:0] exp_sec(input bit p, input bit e);
        exp_sec = 8'h00;
        exp_sec[SEC_PSB_BIT] = p;
        exp_sec[SEC_ESB_BIT] = e;
    endfunction
    function automatic logic [63:0] exp_pwd(input logic [63:0] d, input bit mode_n);
        return mode_n ? (PWD_DEFAULT & d) : PWD_HIDDEN;
    endfunction
    task automatic chk(input string name, input logic [63:0] e, input logic [63:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask
    // Frame then the idle gap the decoder needs
    task automatic frame(input logic [7:0] op, input int n, input bit q);
        fsr_host_model_inst.send_frame({op, a}, n, q, 3'($random(seed)));
        repeat (8) @(posedge clk);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        a = 24'($random(seed));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk("pwd_reset", PWD_DEFAULT, prd);
        chk("outs_reset", 0, {blk, wip, write_enable_latch, sec, four});
        pd <= {$random(seed), $random(seed)};
        prog <= 1'b1;
        @(posedge clk) prog <= 1'b0;
        @(posedge clk);
        chk("pwd_prog", exp_pwd(pd, 1'b1), prd);
        lock_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk("pwd_hidden", exp_pwd(pd, 1'b0), prd);
        // Page program suspended, filtered, refused resume, resumed without write enable
        frame(OP_WRITE_ENABLE, 8, 0);
        frame(OP_PAGE_PROGRAM, 40, 0);
        frame(OP_SUSPEND, 8, 0);
        chk("psb", {exp_sec(1, 0), 2'b00}, {sec, wip, write_enable_latch});
        ra <= a;
        repeat (2) @(posedge clk);
        chk("blk_in", 1, blk);
        ra <= a ^ 24'h00_1000;
        repeat (2) @(posedge clk);
        chk("blk_out", 0, blk);
        r0 = rej_cnt;
        frame(OP_SECTOR_ERASE, 32, 0);
        chk("filter", 1, rej_cnt - r0);
        perf <= 1'b1;
        frame(OP_RESUME, 8, 0);
        chk("perf_hold", exp_sec(1, 0), sec);
        perf <= 1'b0;
        frame(OP_RESUME, 8, 0);
        chk("resume", {exp_sec(0, 0), 1'b1}, {sec, wip});
        for (i = 0; i < 700 && wip !== 1'b0; i++) @(posedge clk);
        chk("prog_done", 0, wip);
        // Host keeps its spacing from the last resume to the next suspend
        repeat (RESUME_GAP_CYC) @(posedge clk);
        // Four-line erase suspend and its latency
        frame(OP_FOUR_LINE_ON, 8, 0);
        frame(OP_WRITE_ENABLE, 2, 1);
        frame(OP_SECTOR_ERASE, 8, 1);
        frame(OP_SUSPEND, 2, 1);
        for (i = 0; i < SUSP_LAT_CYC && sec !== exp_sec(0, 1); i++) @(posedge clk);
        chk("esb", {exp_sec(0, 1), 2'b10}, {sec, four, write_enable_latch});
        chk("esb_late", 1, i > SUSP_LAT_CYC - 40);
        ra <= a;
        repeat (2) @(posedge clk);
        chk("blk_erase", 1, blk);
        // Cancelled arm, then a real soft reset that aborts the erase
        r0 = srst_cnt;
        frame(OP_RESET_ARM, 2, 1);
        frame(OP_NO_OPERATION, 2, 1);
        frame(OP_RESET, 2, 1);
        chk("nop_cancel", {32'h0, exp_sec(0, 1)}, {srst_cnt - r0, sec});
        frame(OP_RESET_ARM, 2, 1);
        frame(OP_RESET, 2, 1);
        chk("soft_reset", 1, srst_cnt - r0);
        chk("after_reset", 0, {wip, write_enable_latch, sec, four});
        repeat (20) @(posedge clk);
        r0 = rej_cnt;
        frame(OP_WRITE_ENABLE, 7, 0);
        chk("off_byte", 2'b10, {1'(rej_cnt - r0), write_enable_latch});
        final_report();
    end
endmodule

// file: sim/fsr_host_model.sv
// Host controller model: drives chip select, link clock and data lines.
// Assumes the bench leaves at least 6 system clocks between frames.
// Select is held low past the last bit so a 50 ns system clock samples it three times.
`timescale 1ns/1ns
module fsr_host_model
(
    output logic       sclk, // Link clock, still outside frames
    output logic       cs_n, // Chip select, active low
    output logic [3:0] sio   // Data lines
);
    // Idle link at time zero
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sio  = 4'h5;
    end
    // One frame, first byte in data[31:24]; bytes past four repeat the word
    task automatic send_frame(input logic [31:0] d, input int n, input bit q, input logic [2:0] junk);
        #2 cs_n = 1'b0;
        for (int k = 0; k < n; k++)
        begin
            sio = q ? d[31-((4*k)%32) -: 4] : {junk, d[31-(k%32)]};
            #3 sclk = 1'b1;
            #3 sclk = 1'b0;
        end
        // Link clock stands still here; a short low select would slip past the synchroniser
        #150 cs_n = 1'b1;
        sio = ~sio;     // Released lines must not keep the last value
    endtask
endmodule
